// ---- core/cid_core.sv ----
// Behaviour
// (RL1) low-power halt op stops instruction processing in a standby state
// (RL2) standby ends on reset or interrupt level at or above programmed level
// (RL3) table op takes two bounding entries and interpolates linearly between them
// (RL4) table op accepts byte, word and longword sizes
// (RL5) table result rounded to nearest, or unrounded with fraction for byte/word
// (RL6) unimplemented encodings trap so software can emulate them
// (RL7) instructions span one to seven 16-bit words
// (RL8) operation and total length come from the first word only
// (RL9) extension words are interpreted according to the operation word
// (RL10) operands located by register field, address-mode field or implicit register
// (RL11) register number from register field; other fields pick data or address
// (RL12) eight data and eight address registers, selectable by instruction fields
// (RL13) low byte of status word holds extend, negative, zero, overflow, carry
// (RL14) long multiply splits product: high 32 bits and low 32 bits to two registers
// (RL15) control moves reach vector base and both space code registers
// (RL16) later-family extensions decoded; earlier object code runs unchanged
// (RL17) each space code register holds a 3-bit address space code
// (RL18) exception vector address is vector base plus vector displacement
// (RL19) operation word is fully fetched before an unimplemented-op trap
`timescale 1ns/100ps
module cid_core (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory
  output cid_pkg::cid_fetch_t imem_o,
  input wire logic imem_ack,
  input wire logic [15:0] imem_rdata,
  // system
  input wire logic [2:0] irq_level,
  output logic low_power,
  output logic trap,
  output logic irq
);
  cid_pkg::cid_state_t st_r, st_nxt;
  cid_pkg::cid_kind_t kind_r;
  cid_pkg::cid_dec_t dec;
  cid_pkg::cid_rfw_t rfw0, rfw1;
  logic [31:0] rf_r [16];
  logic [15:0] ext_r [cid_pkg::MAX_EXT];
  logic [15:0] opw_r, status_word_r;
  logic [31:0] pc_r, op_pc_r, vector_base_pointer_r, trap_pc_r, vec_addr_r, prdata_r;
  logic [2:0] source_space_code_reg_r, dest_space_code_reg_r, ext_cnt_r, ext_need_r;
  logic [7:0] tbl_frac_r;
  logic [3:0] rsel_r;
  logic run_r, trap_r;
  logic [cid_pkg::NEV-1:0] stat_r, mask_r, ev;
  logic ex_trap, ccr_we, cr_we, trap_now, wake;
  logic [4:0] ccr_nxt;

  // length and kind from the operation word alone; extension words only refine
  function automatic cid_pkg::cid_dec_t decode(input logic [15:0] w);
    cid_pkg::cid_dec_t d;
    d = '{ok: 1'b1, len: 3'd1, kind: cid_pkg::K_NOP};
    if (w == cid_pkg::OP_NOP) begin // RL8
      d.kind = cid_pkg::K_NOP;
    end else if (w[15:12] == cid_pkg::OP_MOVEQ && !w[8]) begin
      d.kind = cid_pkg::K_MOVEQ;
    end else if (w == cid_pkg::OP_CRD || w == cid_pkg::OP_CWR) begin // RL16
      d.kind = w[0] ? cid_pkg::K_CWR : cid_pkg::K_CRD;
      d.len = 3'd2;
    end else if (w == cid_pkg::OP_HALT) begin
      d.kind = cid_pkg::K_HALT;
      d.len = 3'd3;
    end else if (w[15:8] == cid_pkg::OP_TBL_HI) begin
      d.kind = cid_pkg::K_TBL;
      d.len = 3'd2;
    end else if (w[15:6] == cid_pkg::OP_MUL_HI && w[5:3] == 3'd0) begin // RL10
      d.kind = cid_pkg::K_MUL;
      d.len = 3'd2;
    end else if (w[15:6] == cid_pkg::OP_MUL_HI && w[5:0] == cid_pkg::EA_IMM) begin
      d.kind = cid_pkg::K_MUL;
      d.len = 3'd4;
    end else begin
      d.ok = 1'b0; // RL6
    end
    return d;
  endfunction

  // size-extend a table entry to a common signed width
  function automatic logic [33:0] tsx(input logic [31:0] v, input logic [1:0] sz,
                                      input logic sg);
    logic [33:0] r;
    r = {{2{sg & v[31]}}, v};
    if (sz == 2'b00) r = {{26{sg & v[7]}}, v[7:0]};
    if (sz == 2'b01) r = {{18{sg & v[15]}}, v[15:0]};
    return r;
  endfunction

  // ---- bus decode ----
  wire acc_w = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire w_ctrl = acc_w && paddr == cid_pkg::A_CTRL;
  wire w_stat = acc_w && paddr == cid_pkg::A_STAT;
  wire w_mask = acc_w && paddr == cid_pkg::A_MASK;
  wire w_pc = acc_w && paddr == cid_pkg::A_PC;
  wire w_vbr = acc_w && paddr == cid_pkg::A_VBR;
  wire w_sfc = acc_w && paddr == cid_pkg::A_SFC;
  wire w_dfc = acc_w && paddr == cid_pkg::A_DFC;
  wire w_sr = acc_w && paddr == cid_pkg::A_SR;
  wire w_rsel = acc_w && paddr == cid_pkg::A_RSEL;
  wire w_rdat = acc_w && paddr == cid_pkg::A_RDAT;
  logic [31:0] rd_val;
  logic mapped;
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      cid_pkg::A_CTRL: rd_val = {31'd0, run_r};
      cid_pkg::A_STAT: rd_val = {28'd0, stat_r};
      cid_pkg::A_MASK: rd_val = {28'd0, mask_r};
      cid_pkg::A_PC: rd_val = pc_r;
      cid_pkg::A_VBR: rd_val = vector_base_pointer_r;
      cid_pkg::A_SFC: rd_val = {29'd0, source_space_code_reg_r};
      cid_pkg::A_DFC: rd_val = {29'd0, dest_space_code_reg_r};
      cid_pkg::A_SR: rd_val = {16'd0, status_word_r};
      cid_pkg::A_OPW: rd_val = {16'd0, opw_r};
      cid_pkg::A_RSEL: rd_val = {28'd0, rsel_r};
      cid_pkg::A_RDAT: rd_val = rf_r[rsel_r];
      cid_pkg::A_FRAC: rd_val = {24'd0, tbl_frac_r};
      cid_pkg::A_TPC: rd_val = trap_pc_r;
      cid_pkg::A_VEC: rd_val = vec_addr_r;
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  // ---- execute datapath ----
  wire [15:0] x0 = ext_r[0];
  wire [11:0] cr_code = x0[11:0];
  wire cr_ok = cr_code == cid_pkg::CR_SFC || cr_code == cid_pkg::CR_DFC ||
               cr_code == cid_pkg::CR_VBR; // RL15
  wire [31:0] cr_val = cr_code == cid_pkg::CR_SFC ? {29'd0, source_space_code_reg_r} :
                       cr_code == cid_pkg::CR_DFC ? {29'd0, dest_space_code_reg_r} :
                       vector_base_pointer_r;
  // bit 15 of the extension picks address over data register
  wire [31:0] cr_src = rf_r[x0[15:12]]; // RL11
  wire [31:0] mq_val = {{24{opw_r[7]}}, opw_r[7:0]};
  wire [31:0] mul_a = rf_r[{1'b0, x0[14:12]}];
  wire [31:0] mul_s = opw_r[5] ? {ext_r[1], ext_r[2]} : rf_r[{1'b0, opw_r[2:0]}]; // RL9
  wire signed [65:0] mul_p = $signed({x0[11] & mul_a[31], mul_a}) *
                             $signed({x0[11] & mul_s[31], mul_s});
  wire [1:0] t_sz = opw_r[7:6];
  wire t_unr = opw_r[5];
  wire [33:0] t_ym = tsx(rf_r[{1'b0, opw_r[2:0]}], t_sz, opw_r[4]); // RL3
  wire [33:0] t_yn = tsx(rf_r[{1'b0, x0[2:0]}], t_sz, opw_r[4]);
  wire [7:0] t_frac = rf_r[{1'b0, x0[14:12]}][7:0];
  wire signed [33:0] t_diff = $signed(t_yn) - $signed(t_ym);
  wire signed [42:0] t_prod = t_diff * $signed({1'b0, t_frac});
  wire signed [42:0] t_base = {t_ym[33], t_ym, 8'h00};
  // rounded form adds one half before the fraction is dropped
  // the half must stay signed, or a falling table would lose the sign of its slope
  wire signed [42:0] t_half = $signed({34'd0, cid_pkg::RND_HALF});
  wire signed [42:0] t_sum = t_base + t_prod + (t_unr ? 43'sd0 : t_half);
  wire [31:0] t_res = t_unr ? t_sum[31:0] : t_sum[39:8]; // RL5
  // longword unrounded would lose bits; size 3 is not a size
  wire t_bad = t_sz == 2'b11 || (t_unr && t_sz == 2'b10); // RL4

  always_comb begin
    rfw0 = '0;
    rfw1 = '0;
    ex_trap = 1'b0;
    ccr_we = 1'b0;
    cr_we = 1'b0;
    ccr_nxt = status_word_r[4:0];
    if (st_r == cid_pkg::ST_EXEC) begin
      unique case (kind_r)
        cid_pkg::K_MOVEQ: begin
          rfw0 = '{we: 1'b1, sel: {1'b0, opw_r[11:9]}, d: mq_val}; // RL11
          ccr_we = 1'b1;
          ccr_nxt = {status_word_r[cid_pkg::SR_X], mq_val[31], mq_val == 32'd0, 2'b00}; // RL13
        end
        cid_pkg::K_CRD: begin
          ex_trap = !cr_ok;
          rfw0 = '{we: cr_ok, sel: x0[15:12], d: cr_val};
        end
        cid_pkg::K_CWR: begin
          ex_trap = !cr_ok;
          cr_we = cr_ok;
        end
        cid_pkg::K_HALT: ex_trap = x0 != cid_pkg::HALT_EXT;
        cid_pkg::K_MUL: begin
          rfw0 = '{we: 1'b1, sel: {1'b0, x0[14:12]}, d: mul_p[31:0]};
          rfw1 = '{we: x0[10], sel: {1'b0, x0[2:0]}, d: mul_p[63:32]}; // RL14
          ccr_we = 1'b1;
          ccr_nxt = {status_word_r[cid_pkg::SR_X], x0[10] ? mul_p[63] : mul_p[31],
                     x0[10] ? mul_p[63:0] == 64'd0 : mul_p[31:0] == 32'd0, 2'b00};
        end
        cid_pkg::K_TBL: begin
          ex_trap = t_bad;
          rfw0 = '{we: !t_bad, sel: {1'b0, x0[14:12]}, d: t_res};
          ccr_we = !t_bad;
          ccr_nxt = {status_word_r[cid_pkg::SR_X], t_res[31], t_res == 32'd0, 2'b00};
        end
        cid_pkg::K_NOP: ;
        default: ex_trap = 1'b1;
      endcase
    end
  end

  // ---- sequencer ----
  wire opw_done = st_r == cid_pkg::ST_OPW && imem_ack;
  wire ext_done = st_r == cid_pkg::ST_EXT && imem_ack;
  assign dec = decode(imem_rdata);
  // trap only once the whole operation word is in, so the trap pc is exact
  assign trap_now = (opw_done && !dec.ok) || ex_trap; // RL19
  assign wake = irq_level != 3'd0 &&
                irq_level >= status_word_r[cid_pkg::SR_IPL +: 3]; // RL2
  wire [3:0] trap_line = opw_done ? imem_rdata[15:12] : opw_r[15:12];
  wire [7:0] trap_vec = trap_line == cid_pkg::LINE_F ? cid_pkg::VEC_FLINE : cid_pkg::VEC_ILL;
  assign imem_o = '{req: st_r == cid_pkg::ST_OPW || st_r == cid_pkg::ST_EXT, addr: pc_r};

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      cid_pkg::ST_IDLE: if (run_r) st_nxt = cid_pkg::ST_OPW;
      cid_pkg::ST_OPW: begin
        if (imem_ack) begin
          st_nxt = !dec.ok ? cid_pkg::ST_IDLE :
                   dec.len == 3'd1 ? cid_pkg::ST_EXEC : cid_pkg::ST_EXT;
        end
      end
      cid_pkg::ST_EXT: if (imem_ack && ext_cnt_r == ext_need_r - 3'd1) st_nxt = cid_pkg::ST_EXEC;
      cid_pkg::ST_EXEC: begin
        if (ex_trap || !run_r) begin
          st_nxt = cid_pkg::ST_IDLE;
        end else if (kind_r == cid_pkg::K_HALT) begin
          st_nxt = cid_pkg::ST_HALT; // RL1
        end else begin
          st_nxt = cid_pkg::ST_OPW;
        end
      end
      cid_pkg::ST_HALT: if (wake) st_nxt = cid_pkg::ST_OPW; // RL2
      default: st_nxt = cid_pkg::ST_IDLE;
    endcase
  end
  assign low_power = st_r == cid_pkg::ST_HALT; // RL1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= cid_pkg::ST_IDLE;
      pc_r <= cid_pkg::PC_RST;
      op_pc_r <= cid_pkg::PC_RST;
      opw_r <= 16'h0000;
      kind_r <= cid_pkg::K_NOP;
      ext_cnt_r <= 3'd0;
      ext_need_r <= 3'd0;
    end else begin
      st_r <= st_nxt;
      if (w_pc) pc_r <= pwdata;
      else if (opw_done || ext_done) pc_r <= pc_r + cid_pkg::WORD_STEP;
      if (opw_done) begin
        opw_r <= imem_rdata;
        op_pc_r <= pc_r;
        kind_r <= dec.kind;
        ext_need_r <= dec.len - 3'd1; // RL7
        ext_cnt_r <= 3'd0;
      end else if (ext_done) begin
        ext_cnt_r <= ext_cnt_r + 3'd1;
      end
    end
  end

  // extension words land in order after the operation word
  for (genvar i = 0; i < cid_pkg::MAX_EXT; i++) begin : g_ext
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ext_r[i] <= 16'h0000;
      else if (ext_done && ext_cnt_r == 3'(i)) ext_r[i] <= imem_rdata; // RL9
    end
  end

  // entries 0-7 data, 8-15 address; core writes win over software
  for (genvar i = 0; i < 16; i++) begin : g_rf
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rf_r[i] <= 32'h0000_0000;
      else if (rfw0.we && rfw0.sel == 4'(i)) rf_r[i] <= rfw0.d; // RL12
      else if (rfw1.we && rfw1.sel == 4'(i)) rf_r[i] <= rfw1.d;
      else if (w_rdat && rsel_r == 4'(i)) rf_r[i] <= pwdata;
    end
  end

  assign ev[cid_pkg::EV_TRAP] = trap_now;
  assign ev[cid_pkg::EV_HALT] = st_r == cid_pkg::ST_EXEC && kind_r == cid_pkg::K_HALT && !ex_trap;
  assign ev[cid_pkg::EV_WAKE] = st_r == cid_pkg::ST_HALT && wake;
  assign ev[cid_pkg::EV_TBL] = st_r == cid_pkg::ST_EXEC && kind_r == cid_pkg::K_TBL && !ex_trap;
  assign irq = |(stat_r & mask_r);
  assign trap = trap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      trap_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
      rsel_r <= 4'h0;
      prdata_r <= 32'h0000_0000;
      trap_pc_r <= cid_pkg::PC_RST;
      vec_addr_r <= cid_pkg::VBR_RST;
      tbl_frac_r <= 8'h00;
    end else begin
      trap_r <= trap_now;
      // a new event beats a same-cycle clear
      stat_r <= (stat_r & ~(w_stat ? pwdata[cid_pkg::NEV-1:0] : '0)) | ev;
      if (w_mask) mask_r <= pwdata[cid_pkg::NEV-1:0];
      if (w_rsel) rsel_r <= pwdata[3:0];
      if (setup) prdata_r <= rd_val;
      if (trap_now) run_r <= 1'b0; // RL6
      else if (w_ctrl) run_r <= pwdata[0];
      if (trap_now) begin
        trap_pc_r <= opw_done ? pc_r : op_pc_r;
        vec_addr_r <= vector_base_pointer_r + {22'd0, trap_vec, 2'b00}; // RL18
      end
      if (ev[cid_pkg::EV_TBL] && t_unr) tbl_frac_r <= t_sum[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word_r <= cid_pkg::SR_RST;
      vector_base_pointer_r <= cid_pkg::VBR_RST;
      source_space_code_reg_r <= 3'd0;
      dest_space_code_reg_r <= 3'd0;
    end else begin
      if (ev[cid_pkg::EV_HALT]) status_word_r <= ext_r[1] & cid_pkg::SR_WMASK;
      else if (ccr_we) status_word_r[4:0] <= ccr_nxt; // RL13
      else if (w_sr) status_word_r <= pwdata[15:0] & cid_pkg::SR_WMASK;
      if (cr_we && cr_code == cid_pkg::CR_VBR) vector_base_pointer_r <= cr_src; // RL15
      else if (w_vbr) vector_base_pointer_r <= pwdata;
      if (cr_we && cr_code == cid_pkg::CR_SFC) source_space_code_reg_r <= cr_src[2:0]; // RL17
      else if (w_sfc) source_space_code_reg_r <= pwdata[2:0];
      if (cr_we && cr_code == cid_pkg::CR_DFC) dest_space_code_reg_r <= cr_src[2:0];
      else if (w_dfc) dest_space_code_reg_r <= pwdata[2:0];
    end
  end

  // ---- checks ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_halt_quiet;
    st_r == cid_pkg::ST_HALT |-> !imem_o.req && low_power;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("fetch during standby"); // RL1
  property p_wake;
    st_r == cid_pkg::ST_HALT && wake |=> st_r == cid_pkg::ST_OPW && stat_r[cid_pkg::EV_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("no resume on interrupt"); // RL2
  property p_stay;
    st_r == cid_pkg::ST_HALT && !wake |=> st_r == cid_pkg::ST_HALT;
  endproperty
  a_stay: assert property (p_stay) else $error("standby left early"); // RL2
  property p_unimpl;
    opw_done && !dec.ok |=> trap && st_r == cid_pkg::ST_IDLE && trap_pc_r == $past(pc_r);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("no trap on bad op"); // RL6
  property p_vec;
    trap_now |=> vec_addr_r == $past(vector_base_pointer_r) + {22'd0, $past(trap_vec), 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong"); // RL18
  property p_len;
    st_r == cid_pkg::ST_EXT |-> ext_cnt_r < ext_need_r && ext_need_r <= 3'd6;
  endproperty
  a_len: assert property (p_len) else $error("too many extension words"); // RL7
  property p_mul;
    st_r == cid_pkg::ST_EXEC && kind_r == cid_pkg::K_MUL && x0[10] && x0[2:0] != x0[14:12]
      |=> rf_r[{1'b0, $past(x0[2:0])}] == $past(mul_p[63:32]) &&
          rf_r[{1'b0, $past(x0[14:12])}] == $past(mul_p[31:0]);
  endproperty
  a_mul: assert property (p_mul) else $error("product split wrong"); // RL14
  property p_tbl_long;
    st_r == cid_pkg::ST_EXEC && kind_r == cid_pkg::K_TBL && t_unr && t_sz == 2'b10
      |=> trap && !stat_r[cid_pkg::EV_TBL] || $past(stat_r[cid_pkg::EV_TBL]);
  endproperty
  a_tbl_long: assert property (p_tbl_long) else $error("long unrounded not refused"); // RL5
  property p_ccr;
    status_word_r[7:5] == 3'b000;
  endproperty
  a_ccr: assert property (p_ccr) else $error("flag byte layout broken"); // RL13
  property p_space;
    cr_we && cr_code == cid_pkg::CR_SFC |=> source_space_code_reg_r == $past(cr_src[2:0]);
  endproperty
  a_space: assert property (p_space) else $error("space code not loaded"); // RL17
  c_halt: cover property (ev[cid_pkg::EV_HALT] ##[1:50] ev[cid_pkg::EV_WAKE]);
  c_trap: cover property (opw_done && !dec.ok);
  c_tbl: cover property (ev[cid_pkg::EV_TBL] && t_unr);
  c_mul: cover property (st_r == cid_pkg::ST_EXEC && kind_r == cid_pkg::K_MUL && x0[10]);
endmodule

// ---- inc/cid_pkg.sv ----
package cid_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_PC = 8'h0C;
  localparam logic [7:0] A_VBR = 8'h10;
  localparam logic [7:0] A_SFC = 8'h14;
  localparam logic [7:0] A_DFC = 8'h18;
  localparam logic [7:0] A_SR = 8'h1C;
  localparam logic [7:0] A_OPW = 8'h20;
  localparam logic [7:0] A_RSEL = 8'h24;
  localparam logic [7:0] A_RDAT = 8'h28;
  localparam logic [7:0] A_FRAC = 8'h2C;
  localparam logic [7:0] A_TPC = 8'h30;
  localparam logic [7:0] A_VEC = 8'h34;
  // event bits in status and mask
  localparam int EV_TRAP = 0;
  localparam int EV_HALT = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_TBL = 3;
  localparam int NEV = 4;
  // status word fields
  localparam int SR_V = 1;
  localparam int SR_X = 4;
  localparam int SR_IPL = 8;
  localparam logic [15:0] SR_RST = 16'h2700;
  localparam logic [15:0] SR_WMASK = 16'hFF1F;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] VBR_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0002;
  // operation words
  localparam logic [15:0] OP_NOP = 16'h4E71;
  localparam logic [15:0] OP_CRD = 16'h4E7A;
  localparam logic [15:0] OP_CWR = 16'h4E7B;
  localparam logic [15:0] OP_HALT = 16'hF800;
  localparam logic [15:0] HALT_EXT = 16'h01C0;
  localparam logic [7:0] OP_TBL_HI = 8'hF9;
  localparam logic [9:0] OP_MUL_HI = 10'h130;
  localparam logic [5:0] EA_IMM = 6'h3C;
  localparam logic [3:0] OP_MOVEQ = 4'h7;
  localparam logic [3:0] LINE_F = 4'hF;
  localparam logic [11:0] CR_SFC = 12'h000;
  localparam logic [11:0] CR_DFC = 12'h001;
  localparam logic [11:0] CR_VBR = 12'h801;
  localparam logic [7:0] VEC_ILL = 8'h04;
  localparam logic [7:0] VEC_FLINE = 8'h0B;
  localparam int MAX_EXT = 6;
  localparam logic [8:0] RND_HALF = 9'h080;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPW = 5'b00010,
    ST_EXT = 5'b00100,
    ST_EXEC = 5'b01000,
    ST_HALT = 5'b10000
  } cid_state_t;
  typedef enum logic [2:0] {K_NOP, K_MOVEQ, K_CRD, K_CWR, K_HALT, K_MUL, K_TBL} cid_kind_t;
  typedef struct packed {logic ok; logic [2:0] len; cid_kind_t kind;} cid_dec_t;
  typedef struct packed {logic req; logic [31:0] addr;} cid_fetch_t;
  typedef struct packed {logic we; logic [3:0] sel; logic [31:0] d;} cid_rfw_t;
endpackage

// ---- dv/cid_imem_model.sv ----
`timescale 1ns/100ps
module cid_imem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fetch port
  input wire cid_pkg::cid_fetch_t fetch,
  input wire logic slow,
  output logic ack,
  output logic [15:0] rdata
);
  logic [15:0] mem [256];
  logic [15:0] last_r;
  logic go_r;
  // random stalls force the core to hold its request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b1;
      last_r <= 16'h0000;
    end else begin
      go_r <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
      if (ack) begin
        last_r <= rdata;
      end
    end
  end
  assign ack = fetch.req & go_r;
  // no stale word outside an ack
  assign rdata = ack ? mem[fetch.addr[8:1]] : ~last_r;
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, imem_ack, pready, pslverr;
  logic low_power, trap, irq, slow, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, vbr_m, v, a, b, e;
  logic [63:0] p;
  logic [15:0] imem_rdata;
  logic [11:0] c;
  logic [2:0] irq_level;
  logic [6:0] base;
  logic [15:0] prog[$];
  logic [31:0] vals[16];
  cid_pkg::cid_fetch_t imem_o;
  int errors, comparisons;
  cid_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .imem_o(imem_o), .imem_ack(imem_ack), .imem_rdata(imem_rdata),
    .irq_level(irq_level), .low_power(low_power), .trap(trap), .irq(irq));
  cid_imem_model u_imem (.pclk(pclk), .presetn(presetn), .fetch(imem_o), .slow(slow),
    .ack(imem_ack), .rdata(imem_rdata));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
    comparisons++;
    if (got !== x) begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] x, input string m);
    apb(1'b0, ad, 32'h0000_0000);
    chk(rd, x, m);
  endtask
  task automatic setreg(input int i, input logic [31:0] d);
    wr(cid_pkg::A_RSEL, 32'(i));
    wr(cid_pkg::A_RDAT, d);
  endtask
  task automatic getreg(input int i, input logic [31:0] x, input logic [31:0] mk);
    wr(cid_pkg::A_RSEL, 32'(i));
    apb(1'b0, cid_pkg::A_RDAT, 32'h0000_0000);
    chk(rd & mk, x & mk, "register");
  endtask
  // every program ends in an unimplemented word, so its trap marks completion
  task automatic start;
    base = 7'($urandom_range(0, 100));
    prog.push_back(16'hF000);
    foreach (prog[i]) u_imem.mem[base + i] = prog[i];
    wr(cid_pkg::A_STAT, 32'h0000_000F);
    wr(cid_pkg::A_PC, {24'h00_0000, base, 1'b0});
    wr(cid_pkg::A_CTRL, 32'h0000_0001);
  endtask
  task automatic fin(input int tix, input logic [7:0] vec);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (trap !== 1'b1 && n < 400);
    chk(32'(n < 400), 32'h0000_0001, "trap");
    rdc(cid_pkg::A_TPC, {24'h00_0000, base, 1'b0} + 32'(2 * tix), "trap pc");
    if (vec != 8'h00) begin
      rdc(cid_pkg::A_VEC, vbr_m + 32'({vec, 2'b00}), "vector");
    end
    rdc(cid_pkg::A_CTRL, 32'h0000_0000, "run");
    prog.delete();
  endtask
  function automatic logic [31:0] tbl_exp(input logic [31:0] ym, dif, f, input int u);
    logic [31:0] t;
    t = dif * f;
    return u ? (ym << 8) + t : ym + ((t + 32'h0000_0080) >> 8);
  endfunction
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    $display("[FAIL] %0t watchdog", $time);
    end_of_test();
  end
  initial begin
    {errors, comparisons} = '0;
    {presetn, psel, penable, pwrite, slow} = '0;
    {paddr, pwdata, irq_level, vbr_m} = '0;
    void'($urandom(32'hfbb3_2df9));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(cid_pkg::A_STAT, 32'h0000_0000, "status reset");
    rdc(cid_pkg::A_SR, {16'h0000, cid_pkg::SR_RST}, "word reset");
    rdc(cid_pkg::A_VBR, 32'h0000_0000, "base reset");
    wr(8'hF0, $urandom());
    chk(32'(last_err), 32'h0000_0001, "unmapped");
    wr(cid_pkg::A_SR, 32'hFFFF_FFFF);
    rdc(cid_pkg::A_SR, {16'h0000, cid_pkg::SR_WMASK}, "flags");
    for (int i = 0; i < 16; i++) begin
      vals[i] = $urandom();
      setreg(i, vals[i]);
    end
    for (int i = 0; i < 16; i++) getreg(i, vals[i], '1);
    $display("test registers done");
    slow <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      v = $urandom() & 32'hFFFF_FFFC;
      c = k == 0 ? cid_pkg::CR_SFC : k == 1 ? cid_pkg::CR_DFC : cid_pkg::CR_VBR;
      setreg(1, v);
      prog = '{cid_pkg::OP_CWR, {4'h1, c}, cid_pkg::OP_CRD, {4'h4, c}};
      e = k < 2 ? v & 32'h0000_0007 : v;
      if (k == 2) vbr_m = v;
      start();
      fin(4, cid_pkg::VEC_FLINE);
      rdc(k == 0 ? cid_pkg::A_SFC : k == 1 ? cid_pkg::A_DFC : cid_pkg::A_VBR, e, "ctl");
      getreg(4, e, '1);
    end
    prog = '{cid_pkg::OP_CWR, 16'h1002};
    start();
    fin(0, cid_pkg::VEC_ILL);
    for (int r = 0; r < 8; r++) begin
      v = $urandom();
      prog = '{{cid_pkg::OP_MOVEQ, 3'(r), 1'b0, v[7:0]}};
      start();
      fin(1, cid_pkg::VEC_FLINE);
      getreg(r, {{24{v[7]}}, v[7:0]}, '1);
    end
    $display("test control and quick moves done");
    for (int m = 0; m < 2; m++) begin
      a = $urandom();
      b = $urandom();
      setreg(1, a);
      setreg(2, b);
      p = m ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0000_0000, a} * {32'h0000_0000, b};
      if (m == 0) prog = '{16'h4C01, 16'h2403};
      else prog = '{16'h4C3C, 16'h2C03, a[31:16], a[15:0]};
      start();
      fin(m ? 4 : 2, cid_pkg::VEC_FLINE);
      getreg(2, p[31:0], '1);
      getreg(3, p[63:32], '1);
    end
    $display("test multiply done");
    for (int s = 0; s < 4; s++) begin
      for (int u = 0; u < 2; u++) begin
        a = $urandom_range(0, s == 0 ? 127 : s == 1 ? 32767 : 32'h00FF_FFFF);
        b = $urandom_range(0, s == 0 ? 127 : s == 1 ? 32767 : 32'h00FF_FFFF);
        v = $urandom_range(1, 255);
        setreg(1, a);
        setreg(2, a + b);
        setreg(3, v);
        prog = '{{8'hF9, 2'(s), 1'(u), 5'b00001}, 16'h3002};
        start();
        if (s == 3 || (s == 2 && u == 1)) begin
          fin(0, 8'h00);
        end else begin
          fin(2, cid_pkg::VEC_FLINE);
          e = tbl_exp(a, b, v, u);
          getreg(3, e, u ? '1 : ~(32'hFFFF_FFFF << (8 << s)));
          if (u) rdc(cid_pkg::A_FRAC, e & 32'h0000_00FF, "fraction");
        end
      end
    end
    $display("test table done");
    wr(cid_pkg::A_MASK, 32'h0000_000F);
    prog = '{cid_pkg::OP_HALT, cid_pkg::HALT_EXT, 16'h2300};
    start();
    repeat (40) @(negedge pclk);
    chk(32'(low_power), 32'h0000_0001, "standby");
    chk(32'(irq), 32'h0000_0001, "halt event");
    @(posedge pclk);
    irq_level <= 3'h2;
    repeat (20) @(negedge pclk);
    chk(32'(low_power), 32'h0000_0001, "below level");
    @(posedge pclk);
    irq_level <= 3'h3;
    fin(3, cid_pkg::VEC_FLINE);
    irq_level <= 3'h0;
    chk(32'(low_power), 32'h0000_0000, "awake");
    rdc(cid_pkg::A_SR, 32'h0000_2300, "new word");
    rdc(cid_pkg::A_STAT, 32'h0000_0007, "events");
    $display("test standby done");
    wr(cid_pkg::A_MASK, 32'h0000_0000);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0000, "masked");
    wr(cid_pkg::A_MASK, 32'h0000_0001);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0001, "unmasked");
    wr(cid_pkg::A_STAT, 32'h0000_0001);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0000, "cleared");
    $display("test interrupt done");
    end_of_test();
  end
endmodule
